// ==== rtl/irq_inc_exec.sv ====
// Purpose: Executes interrupt enable/disable and increment on a flags word and operand
// Assumes: Software issues commands over Avalon-MM; one command retires per write
// Notes: Hold after enable is released by the next executed command
// Function
// - Disable may land one instruction late; guard sequences with one instruction. Here the clear lands as disable retires.
// - Enable ORs 0008h into the flags word, a bit-set of immediate 8.
// - Enable keeps negative, zero, carry and overflow flags.
// - Enable keeps oscillator-off and core-off bits; only global enable changes.
// - After enable, the next instruction runs before any interrupt is accepted.
// - Increment adds one to destination, same as add immediate one.
// - Increment has word form, the default, and a byte form.
// - Negative flag follows the result's most significant bit.
// - Word zero flag set only when destination held 0FFFFh.
// - Word carry flag set only when destination held 0FFFFh.
// - Word overflow flag set only when destination held 07FFFh.
// - Increment keeps oscillator-off, core-off and global enable bits.
// - Disable ANDs the flags word with 0FFF7h, nothing else changes.
module irq_inc_exec
    import irq_inc_pkg::*;
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // Avalon-MM slave
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Interrupt acceptance
    input wire logic IRQ_PENDING,
    output logic IRQ_ACCEPT,
    output logic GLOBAL_IRQ_ENABLE
);
    typedef struct packed {
        bus_state_t st;
        logic [15:0] flags;
        logic [15:0] dst;
        logic [31:0] rdata;
        logic hold_off;
        logic accept;
        logic [2:0] last_cmd;
        logic [2:0] cmd;
        logic sync1;
        logic sync2;
    } state_t;

    state_t r;
    state_t next_r;
    inc_alu_if alu_bus ();

    inc_alu u_alu (
        .bus(alu_bus)
    );

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
        input logic [3:0] be);
        merge16 = old;
        if (be[0]) begin
            merge16[7:0] = wd[7:0];
        end
        if (be[1]) begin
            merge16[15:8] = wd[15:8];
        end
    endfunction

    assign alu_bus.operand = r.dst;
    assign alu_bus.byte_mode = (r.cmd == CMD_INC_B);

    always_comb begin
        next_r = r;
        next_r.accept = 1'b0;
        // Two-stage synchroniser for the asynchronous request pin
        next_r.sync1 = IRQ_PENDING;
        next_r.sync2 = r.sync1;
        unique case (r.st)
            IDLE: begin
                if (AVS_WRITE) begin
                    next_r.st = DONE;
                    unique case (AVS_ADDRESS)
                        CMD_OFS: begin
                            next_r.cmd = AVS_WRITEDATA[2:0];
                            next_r.st = EXEC;
                        end
                        FLAGS_OFS: next_r.flags = merge16(r.flags, AVS_WRITEDATA,
                            AVS_BYTEENABLE);
                        DST_OFS: next_r.dst = merge16(r.dst, AVS_WRITEDATA, AVS_BYTEENABLE);
                        default: next_r.st = DONE;
                    endcase
                end else if (AVS_READ) begin
                    next_r.st = DONE;
                    unique case (AVS_ADDRESS)
                        CMD_OFS: next_r.rdata = {29'h0, r.last_cmd};
                        FLAGS_OFS: next_r.rdata = {16'h0000, r.flags};
                        DST_OFS: next_r.rdata = {16'h0000, r.dst};
                        STAT_OFS: next_r.rdata = {30'h0, r.hold_off, r.flags[IRQ_EN_POS]};
                        default: next_r.rdata = UNMAPPED_READ;
                    endcase
                end else if (r.sync2 && r.flags[IRQ_EN_POS] && !r.hold_off) begin
                    // Acceptance only between instructions, never in the slot after enable
                    next_r.accept = 1'b1;
                    next_r.flags[IRQ_EN_POS] = 1'b0;
                end
            end
            EXEC: begin
                next_r.st = DONE;
                next_r.last_cmd = r.cmd;
                // Any retired instruction other than enable releases the post-enable hold; enable sets it again
                next_r.hold_off = 1'b0;
                unique case (r.cmd)
                    CMD_IRQ_ENABLE: begin
                        next_r.flags = r.flags | ENABLE_MASK;
                        next_r.hold_off = 1'b1;
                    end
                    CMD_IRQ_DISABLE: begin
                        // Clear lands at retire; acceptance is checked only after it
                        next_r.flags = r.flags & DISABLE_MASK;
                    end
                    CMD_INC_W, CMD_INC_B: begin
                        next_r.dst = alu_bus.result;
                        next_r.flags[NEG_POS] = alu_bus.neg;
                        next_r.flags[ZERO_POS] = alu_bus.zero;
                        next_r.flags[CARRY_POS] = alu_bus.carry;
                        next_r.flags[OVF_POS] = alu_bus.ovf;
                    end
                    default: next_r.last_cmd = CMD_NOP;
                endcase
            end
            DONE: next_r.st = IDLE;
            default: next_r.st = IDLE;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            r.st <= IDLE;
            r.flags <= FLAGS_RESET;
            r.dst <= DST_RESET;
            r.rdata <= 32'h0000_0000;
            r.hold_off <= 1'b0;
            r.accept <= 1'b0;
            r.last_cmd <= CMD_NOP;
            r.cmd <= CMD_NOP;
            r.sync1 <= 1'b0;
            r.sync2 <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign AVS_WAITREQUEST = (r.st != DONE);
    assign AVS_READDATA = r.rdata;
    assign IRQ_ACCEPT = r.accept;
    assign GLOBAL_IRQ_ENABLE = r.flags[IRQ_EN_POS];
endmodule

// ==== rtl/irq_inc_pkg.sv ====
// Purpose: Shared constants for the interrupt-enable and increment execution block
// Assumes: 16-bit flags word, Avalon-MM register access with 32-bit data
// Notes: Register offsets are byte addresses of aligned words
package irq_inc_pkg;
    localparam int DATA_W = 16;
    // Flags word bit positions
    localparam int CARRY_POS = 0;
    localparam int ZERO_POS = 1;
    localparam int NEG_POS = 2;
    localparam int IRQ_EN_POS = 3;
    localparam int CORE_OFF_POS = 4;
    localparam int OSC_OFF_POS = 5;
    localparam int OVF_POS = 8;
    localparam logic [15:0] ENABLE_MASK = 16'h0008;
    localparam logic [15:0] DISABLE_MASK = 16'hfff7;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic [15:0] DST_RESET = 16'h0000;
    // Register map
    localparam logic [3:0] CMD_OFS = 4'h0;
    localparam logic [3:0] FLAGS_OFS = 4'h4;
    localparam logic [3:0] DST_OFS = 4'h8;
    localparam logic [3:0] STAT_OFS = 4'hc;
    // Command codes
    localparam logic [2:0] CMD_NOP = 3'h0;
    localparam logic [2:0] CMD_IRQ_ENABLE = 3'h1;
    localparam logic [2:0] CMD_IRQ_DISABLE = 3'h2;
    localparam logic [2:0] CMD_INC_W = 3'h3;
    localparam logic [2:0] CMD_INC_B = 3'h4;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
    typedef enum logic [1:0] {IDLE, EXEC, DONE} bus_state_t;
endpackage

// ==== rtl/inc_alu_if.sv ====
// Purpose: Carries operand and results between the sequencer and the increment unit
// Assumes: Single clock, combinational unit
// Notes: None
interface inc_alu_if;
    logic [15:0] operand;
    logic byte_mode;
    logic [15:0] result;
    logic neg;
    logic zero;
    logic carry;
    logic ovf;
    modport ctrl (output operand, output byte_mode, input result, input neg, input zero,
        input carry, input ovf);
    modport alu (input operand, input byte_mode, output result, output neg, output zero,
        output carry, output ovf);
endinterface

// ==== rtl/inc_alu.sv ====
// Purpose: Increment by one with flag results for word and byte forms
// Assumes: Combinational, operand from a register of the caller
// Notes: Equivalent to adding immediate one
module inc_alu
    import irq_inc_pkg::*;
(
    inc_alu_if.alu bus
);
    logic [16:0] sum;
    always_comb begin
        sum = {1'b0, bus.operand} + 17'h00001;
        if (bus.byte_mode) begin
            bus.result = {8'h00, sum[7:0]};
            bus.neg = sum[7];
            bus.zero = (bus.operand[7:0] == 8'hff);
            bus.carry = (bus.operand[7:0] == 8'hff);
            bus.ovf = (bus.operand[7:0] == 8'h7f);
        end else begin
            bus.result = sum[15:0];
            bus.neg = sum[15];
            bus.zero = (bus.operand == 16'hffff);
            bus.carry = (bus.operand == 16'hffff);
            bus.ovf = (bus.operand == 16'h7fff);
        end
    end
endmodule

// ==== test/irq_inc_monitor.sv ====
// Purpose: Port checks for the flags and increment executor
// Assumes: Register writes answer one cycle after taking, commands two
// Notes: Bound to irq_inc_exec
module irq_inc_monitor
    import irq_inc_pkg::*;
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // Bus
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic AVS_WAITREQUEST,
    // Interrupt side
    input wire logic IRQ_ACCEPT,
    input wire logic GLOBAL_IRQ_ENABLE
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    sequence cmd_start;
        $rose(AVS_WRITE) && AVS_ADDRESS == CMD_OFS;
    endsequence
    sequence cmd_answer;
        AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
    endsequence
    sequence reg_start;
        ($rose(AVS_WRITE) && AVS_ADDRESS != CMD_OFS) || $rose(AVS_READ);
    endsequence
    sequence enable_dropped;
        !GLOBAL_IRQ_ENABLE && $past(GLOBAL_IRQ_ENABLE);
    endsequence
    sequence fall_cause;
        IRQ_ACCEPT || $past(AVS_WRITE);
    endsequence
    sequence enable_by_cmd;
        $rose(GLOBAL_IRQ_ENABLE) && $past(AVS_ADDRESS) == CMD_OFS;
    endsequence
    a_cmd_latency: assert property (cmd_start |=> cmd_answer)
        else $error("cmd late");
    a_reg_latency: assert property (reg_start |=> !AVS_WAITREQUEST)
        else $error("reg answer late");
    a_answer_once: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("answer too long");
    a_accept_pulse: assert property (IRQ_ACCEPT |=> !IRQ_ACCEPT)
        else $error("accept long");
    a_accept_clears: assert property (IRQ_ACCEPT |-> enable_dropped)
        else $error("accept without enable");
    a_enable_set_cause: assert property ($rose(GLOBAL_IRQ_ENABLE) |-> $past(AVS_WRITE))
        else $error("enable without write");
    a_enable_clr_cause: assert property ($fell(GLOBAL_IRQ_ENABLE) |-> fall_cause)
        else $error("enable lost");
    a_enable_hold: assert property (enable_by_cmd |-> !IRQ_ACCEPT [*4])
        else $error("accept right after enable");
endmodule
bind irq_inc_exec irq_inc_monitor u_mon (.MCLK(MCLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .IRQ_ACCEPT(IRQ_ACCEPT), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE));

// ==== test/testbench.sv ====
// Purpose: Self-checking bench for the flags and increment executor
// Assumes: All byte lanes enabled except in the lane test
// Notes: Accepted interrupts are counted from the pulse
module testbench
    import irq_inc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic MCLK = 0, RST = 1, AVS_READ = 0, AVS_WRITE = 0, IRQ_PENDING = 0;
    logic [3:0] AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'hf;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, q;
    logic AVS_WAITREQUEST, IRQ_ACCEPT, GLOBAL_IRQ_ENABLE;
    int bad_count = 0, num_checks = 0, accepts = 0;
    irq_inc_exec u_dut (.MCLK(MCLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .IRQ_PENDING(IRQ_PENDING), .IRQ_ACCEPT(IRQ_ACCEPT), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE));
    initial begin
        forever #5 MCLK = ~MCLK;
    end
    always @(posedge MCLK) begin
        if (IRQ_ACCEPT === 1'b1) accepts++;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
        @(posedge MCLK);
        AVS_ADDRESS <= a;
        AVS_WRITE <= w;
        AVS_READ <= !w;
        AVS_WRITEDATA <= d;
        // Outputs come from registers, so they still show their pre-edge values here
        do begin
            @(posedge MCLK);
        end while (AVS_WAITREQUEST !== 1'b0);
        q = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
        bus(a, 1'b0, 32'h0);
        chk(q, e, nm);
    endtask
    task automatic cmd(input logic [2:0] c);
        bus(CMD_OFS, 1'b1, {29'h0, c});
    endtask
    // Preset mode bits and all arithmetic flags, then increment
    task automatic inc(input logic w, input logic [15:0] d, input logic [15:0] e,
        input logic [15:0] f);
        bus(FLAGS_OFS, 1'b1, 32'h0000_013f);
        bus(DST_OFS, 1'b1, {16'h0, d});
        cmd(w ? CMD_INC_W : CMD_INC_B);
        rd(DST_OFS, {16'h0, e}, "dst");
        rd(FLAGS_OFS, {16'h0, f}, "flags");
    endtask
    task automatic complete_run;
        if (bad_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge MCLK);
        bad_count++;
        complete_run;
    end
    initial begin
        repeat (10) @(posedge MCLK);
        RST <= 1'b0;
        rd(FLAGS_OFS, {16'h0, FLAGS_RESET}, "flags reset");
        rd(STAT_OFS, 32'h0, "status reset");
        chk({31'h0, GLOBAL_IRQ_ENABLE}, 32'h0, "enable reset");
        rd(4'h2, UNMAPPED_READ, "unmapped");
        bus(FLAGS_OFS, 1'b1, 32'h0000_0137);
        bus(4'h2, 1'b1, 32'h0000_ffff);
        rd(FLAGS_OFS, 32'h0000_0137, "flags unmapped write");
        cmd(CMD_IRQ_ENABLE);
        rd(FLAGS_OFS, 32'h0000_013f, "flags enable");
        cmd(CMD_IRQ_DISABLE);
        rd(FLAGS_OFS, 32'h0000_0137, "flags disable");
        inc(1'b1, 16'hffff, 16'h0000, 16'h003b);
        inc(1'b1, 16'h7fff, 16'h8000, 16'h013c);
        inc(1'b1, 16'h1234, 16'h1235, 16'h0038);
        inc(1'b1, 16'h00ff, 16'h0100, 16'h0038);
        inc(1'b0, 16'h12ff, 16'h0000, 16'h003b);
        inc(1'b0, 16'h007f, 16'h0080, 16'h013c);
        inc(1'b0, 16'h0005, 16'h0006, 16'h0038);
        rd(CMD_OFS, {29'h0, CMD_INC_B}, "last cmd");
        bus(DST_OFS, 1'b1, 32'h0000_1234);
        AVS_BYTEENABLE <= 4'h1;
        bus(DST_OFS, 1'b1, 32'h0000_abcd);
        AVS_BYTEENABLE <= 4'hf;
        rd(DST_OFS, 32'h0000_12cd, "dst low lane");
        cmd(3'h7);
        rd(CMD_OFS, 32'h0, "bad cmd");
        cmd(CMD_IRQ_DISABLE);
        IRQ_PENDING <= 1'b1;
        cmd(CMD_IRQ_ENABLE);
        rd(STAT_OFS, 32'h0000_0003, "status hold");
        cmd(CMD_IRQ_DISABLE);
        repeat (8) @(posedge MCLK);
        chk(accepts, 0, "accepts after disable");
        cmd(CMD_IRQ_ENABLE);
        repeat (8) @(posedge MCLK);
        chk(accepts, 0, "accepts held");
        cmd(CMD_NOP);
        repeat (8) @(posedge MCLK);
        chk(accepts, 1, "accepts");
        chk({31'h0, GLOBAL_IRQ_ENABLE}, 32'h0, "enable after accept");
        RST <= 1'b1;
        repeat (2) @(posedge MCLK);
        RST <= 1'b0;
        rd(FLAGS_OFS, {16'h0, FLAGS_RESET}, "flags mid reset");
        cmd(CMD_IRQ_ENABLE);
        rd(FLAGS_OFS, 32'h0000_0008, "flags enable only");
        rd(STAT_OFS, 32'h0000_0003, "status hold again");
        cmd(CMD_NOP);
        repeat (8) @(posedge MCLK);
        chk(accepts, 2, "accepts after reset");
        complete_run;
    end
endmodule
